/* logic/dc_pkg.sv */
// shared constants, timing tables and carrier types for the dram cycle controller
package dc_pkg;

	// clock rate and derived period
	localparam int CLK_MHZ       = 100;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

	// widths of the memory side
	localparam int ADDR_W = 10;            // multiplexed row / column address
	localparam int DATA_W = 16;            // two byte lanes
	localparam int BYTE_W = 8;
	localparam int LANES  = 2;
	localparam int LANE_LO = 0;            // lane index of the low byte
	localparam int LANE_HI = 1;            // lane index of the high byte
	localparam int GRADES = 3;             // index 0 fastest, 2 slowest

	// elapsed counters load this on a clear: one cycle passed at the next edge
	localparam int CNT_START = 1;

	// per-grade timing in ns, fastest grade first
	typedef int dc_tab_t [GRADES];
	localparam dc_tab_t T_ROW_PRE_NS       = '{30, 40, 50};  // row strobe high time
	localparam dc_tab_t T_ROW_ACT_NS       = '{50, 60, 70};  // row strobe low time
	localparam dc_tab_t T_ROW_ADDR_HOLD_NS = '{8, 10, 10};   // row address after row fall
	localparam dc_tab_t T_ROW_COL_ADDR_NS  = '{13, 15, 15};  // row fall to column address
	localparam dc_tab_t T_ROW_TO_COL_NS    = '{18, 20, 20};  // row fall to column fall
	localparam dc_tab_t T_COL_ADDR_HOLD_NS = '{10, 10, 15};  // column address after col fall
	localparam dc_tab_t T_COL_LOW_NS       = '{13, 15, 18};  // column strobe low time
	localparam dc_tab_t T_COL_PRE_NS       = '{8, 10, 10};   // column strobe high time
	localparam dc_tab_t T_ROW_COL_LOW_NS   = '{50, 60, 70};  // row fall to column rise
	localparam dc_tab_t T_ROW_HOLD_PRE_NS  = '{30, 35, 40};  // column rise to row rise
	localparam dc_tab_t T_ADDR_ROW_PRE_NS  = '{25, 30, 35};  // column address to row rise
	localparam dc_tab_t T_ADDR_COL_PRE_NS  = '{25, 30, 35};  // column address to col rise
	localparam dc_tab_t T_COL_ROW_PRE_NS   = '{13, 15, 18};  // column fall to row rise
	localparam dc_tab_t T_WE_HOLD_NS       = '{10, 10, 15};  // early write strobe hold
	localparam dc_tab_t T_DATA_HOLD_NS     = '{10, 10, 15};  // write data hold
	localparam dc_tab_t T_WE_COL_PRE_NS    = '{13, 15, 18};  // write low before col rise
	localparam dc_tab_t T_WE_ROW_PRE_NS    = '{13, 15, 18};  // write low before row rise
	localparam dc_tab_t T_RMW_COL_WE_NS    = '{36, 40, 46};  // col fall to write, read-write
	localparam dc_tab_t T_RMW_ADDR_WE_NS   = '{48, 55, 63};  // col address to write
	localparam dc_tab_t T_RMW_ROW_WE_NS    = '{73, 85, 98};  // row fall to write
	localparam dc_tab_t T_OE_TO_DATA_NS    = '{13, 15, 18};  // oe high to data drive
	localparam dc_tab_t T_ACC_COL_NS       = '{13, 15, 18};  // access from column strobe
	localparam dc_tab_t T_ACC_ADDR_NS      = '{25, 30, 35};  // access from column address
	localparam dc_tab_t T_ACC_ROW_NS       = '{50, 60, 70};  // access from row strobe

	// grade independent timing in ns
	localparam int T_BYTE_OVERLAP_NS = 5;   // first byte strobe low after second falls
	localparam int T_COL_ROW_PRE_GAP_NS = 5; // column high around row edges
	localparam int T_CBR_SETUP_NS    = 5;   // column low before row fall, refresh
	localparam int T_CBR_HOLD_NS     = 10;  // column low after row fall, refresh
	localparam int T_WE_PRE_CBR_NS   = 10;  // write high before row fall, refresh
	localparam int T_WE_POST_CBR_NS  = 10;  // write high after row fall, refresh
	localparam int T_WE_PULSE_NS     = 10;  // write strobe low time
	localparam int T_RASP_MAX_NS     = 100000; // longest page-mode row low time
	localparam int T_PAGE_GUARD_NS   = 1000;   // margin kept before the page limit

	// ns to whole cycles, rounded up, at least one
	function automatic int dc_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : dc_cyc

	// larger of two
	function automatic int dc_max(input int a, input int b);
		return (a > b) ? a : b;
	endfunction : dc_max

	// user commands
	typedef enum logic [1:0] {
		CMD_READ    = 2'h0,
		CMD_WRITE   = 2'h1,
		CMD_RMW     = 2'h2,
		CMD_REFRESH = 2'h3
	} dc_cmd_t;

	// one user request
	typedef struct packed {
		dc_cmd_t             cmd;
		logic [ADDR_W-1:0]   row;
		logic [ADDR_W-1:0]   col;
		logic [LANES-1:0]    byte_en;
		logic [DATA_W-1:0]   wdata;
	} dc_req_t;

	// every pin driven toward the memory
	typedef struct packed {
		logic                row_strobe_n;
		logic                low_byte_column_strobe_n;
		logic                high_byte_column_strobe_n;
		logic                write_strobe_n;
		logic                output_enable_n;
		logic [ADDR_W-1:0]   address;
		logic [BYTE_W-1:0]   low_byte_data;
		logic [BYTE_W-1:0]   high_byte_data;
		logic                low_byte_data_oe;
		logic                high_byte_data_oe;
	} dc_pins_t;

	// all strobes high, bus released
	localparam dc_pins_t PINS_IDLE = '{
		row_strobe_n: 1'b1, low_byte_column_strobe_n: 1'b1,
		high_byte_column_strobe_n: 1'b1, write_strobe_n: 1'b1,
		output_enable_n: 1'b1, address: '0, low_byte_data: '0,
		high_byte_data: '0, low_byte_data_oe: 1'b0, high_byte_data_oe: 1'b0};

endpackage : dc_pkg

/* logic/dc_elapsed.sv */
// saturating counter of cycles elapsed since the last clear
`timescale 1ns/1ns
module dc_elapsed #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clock_in,
	input  wire logic         reset_n_in,
	// control
	input  wire logic         clear_in,
	// elapsed cycles
	output logic [W-1:0]      count_out
);
	import dc_pkg::*;

	typedef struct packed {
		logic [W-1:0] count;
	} dc_elapsed_state_t;

	dc_elapsed_state_t state_reg;   // registered count
	dc_elapsed_state_t state_next;  // next count

	// saturating so a long idle reads as "long ago", never wraps to small
	always_comb begin
		state_next = state_reg;
		if (clear_in) begin
			state_next.count = W'(CNT_START);
		end else if (state_reg.count != '1) begin
			state_next.count = state_reg.count + W'(CNT_START);
		end
	end

	// reset to saturated: nothing recent has happened
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= '{count: '1};
		end else begin
			state_reg <= state_next;
		end
	end

	assign count_out = state_reg.count;

endmodule : dc_elapsed

/* logic/dc_ctrl.sv */
// page-mode dram cycle controller driving strobes, address and data pins
`timescale 1ns/1ns
module dc_ctrl #(
	parameter int GRADE       = 0,              // 0 fastest, 2 slowest
	parameter int RASP_MAX_NS = 100000,         // longest page row low time
	parameter int CNT_W       = 16              // elapsed counter width
) (
	// clock and reset
	input  wire logic              clock_in,
	input  wire logic              reset_n_in,
	// user request
	input  wire logic              req_valid_in,
	input  wire dc_pkg::dc_req_t   req_in,
	output logic                   ready_out,
	// read answer
	output logic [dc_pkg::DATA_W-1:0] rdata_out,
	output logic                   rvalid_out,
	// memory pins
	output dc_pkg::dc_pins_t       pins_out,
	input  wire logic [dc_pkg::BYTE_W-1:0] low_byte_data_in,
	input  wire logic [dc_pkg::BYTE_W-1:0] high_byte_data_in
);
	import dc_pkg::*;

	typedef logic [CNT_W-1:0] dc_cnt_t;

	// cycle counts, rounded up per grade
	localparam dc_cnt_t C_ROW_PHASE = CNT_W'(dc_cyc(dc_max(T_ROW_ADDR_HOLD_NS[GRADE],
		T_ROW_COL_ADDR_NS[GRADE])));
	localparam dc_cnt_t C_ROW_TO_COL = CNT_W'(dc_cyc(T_ROW_TO_COL_NS[GRADE]));
	localparam dc_cnt_t C_COL_PRE = CNT_W'(dc_cyc(dc_max(T_COL_PRE_NS[GRADE],
		T_COL_ROW_PRE_GAP_NS)));
	localparam dc_cnt_t C_COL_LOW = CNT_W'(dc_cyc(dc_max(dc_max(dc_max(T_COL_LOW_NS[GRADE],
		T_ACC_COL_NS[GRADE]), dc_max(T_COL_ADDR_HOLD_NS[GRADE], T_WE_HOLD_NS[GRADE])),
		dc_max(dc_max(T_WE_COL_PRE_NS[GRADE], T_DATA_HOLD_NS[GRADE]),
		dc_max(T_BYTE_OVERLAP_NS, T_COL_ROW_PRE_NS[GRADE])))));
	localparam dc_cnt_t C_COL_ADDR = CNT_W'(dc_cyc(dc_max(T_ADDR_COL_PRE_NS[GRADE],
		T_ACC_ADDR_NS[GRADE])));
	localparam dc_cnt_t C_ROW_COL_LOW = CNT_W'(dc_cyc(dc_max(T_ROW_COL_LOW_NS[GRADE],
		T_ACC_ROW_NS[GRADE])));
	localparam dc_cnt_t C_RMW_COL = CNT_W'(dc_cyc(T_RMW_COL_WE_NS[GRADE]));
	localparam dc_cnt_t C_RMW_ADDR = CNT_W'(dc_cyc(T_RMW_ADDR_WE_NS[GRADE]));
	localparam dc_cnt_t C_RMW_ROW = CNT_W'(dc_cyc(T_RMW_ROW_WE_NS[GRADE]));
	localparam dc_cnt_t C_OE_TO_DATA = CNT_W'(dc_cyc(T_OE_TO_DATA_NS[GRADE]));
	localparam dc_cnt_t C_RMW_WE_LOW = CNT_W'(dc_cyc(dc_max(dc_max(T_WE_PULSE_NS,
		T_WE_COL_PRE_NS[GRADE]), dc_max(T_WE_ROW_PRE_NS[GRADE], T_DATA_HOLD_NS[GRADE]))));
	localparam dc_cnt_t C_ROW_HOLD_PRE = CNT_W'(dc_cyc(T_ROW_HOLD_PRE_NS[GRADE]));
	localparam dc_cnt_t C_ADDR_ROW_PRE = CNT_W'(dc_cyc(T_ADDR_ROW_PRE_NS[GRADE]));
	localparam dc_cnt_t C_ROW_ACT = CNT_W'(dc_cyc(T_ROW_ACT_NS[GRADE]));
	localparam dc_cnt_t C_ROW_PRE = CNT_W'(dc_cyc(dc_max(T_ROW_PRE_NS[GRADE],
		T_COL_ROW_PRE_GAP_NS)));
	localparam dc_cnt_t C_CBR_SETUP = CNT_W'(dc_cyc(T_CBR_SETUP_NS));
	localparam dc_cnt_t C_CBR_HOLD = CNT_W'(dc_cyc(dc_max(T_CBR_HOLD_NS, T_WE_POST_CBR_NS)));
	localparam int      PAGE_LIMIT_CYC = dc_cyc(RASP_MAX_NS) - dc_cyc(T_PAGE_GUARD_NS);
	localparam dc_cnt_t C_PAGE_LIMIT = CNT_W'(PAGE_LIMIT_CYC);

	// refuse settings the logic cannot serve
	if (GRADE < 0 || GRADE >= GRADES) begin : g_bad_grade
		$error("dc_ctrl: speed grade out of range");
	end
	if (PAGE_LIMIT_CYC < 1 || dc_cyc(RASP_MAX_NS) >= (1 << CNT_W) - 1) begin : g_bad_cnt
		$error("dc_ctrl: counter width too small for page limit");
	end

	// one-hot sequencer states
	typedef enum logic [11:0] {
		S_IDLE      = 12'h001,  // bank closed, precharged
		S_ROW       = 12'h002,  // row strobe low, row address held
		S_RCOL      = 12'h004,  // column address out, waiting to strobe
		S_COL       = 12'h008,  // column low: read or early write
		S_RMW_READ  = 12'h010,  // read-write: reading with oe low
		S_RMW_TURN  = 12'h020,  // oe released, bus turnaround
		S_RMW_WRITE = 12'h040,  // write strobe low, data driven
		S_CPRE      = 12'h080,  // column precharge, page open
		S_RPRE      = 12'h100,  // row precharge
		S_CBR_COL   = 12'h200,  // refresh: column low first
		S_CBR_ROW   = 12'h400,  // refresh: row low with column low
		S_CBR_END   = 12'h800   // refresh: column high, row still low
	} dc_state_t;

	// whole module state
	typedef struct packed {
		dc_state_t          st;
		dc_pins_t           pins;
		dc_req_t            cur;     // request in service or pending
		logic               pend;    // cur waits for the bank to close
		logic               ready;
		logic [DATA_W-1:0]  rdata;
		logic               rvalid;
	} dc_core_t;

	localparam dc_core_t CORE_RESET = '{st: S_RPRE, pins: PINS_IDLE, cur: '0,
		pend: 1'b0, ready: 1'b0, rdata: '0, rvalid: 1'b0};

	dc_core_t core_reg;    // registered state
	dc_core_t core_next;   // next state
	dc_cnt_t  ras_cnt;     // cycles since row strobe edge
	dc_cnt_t  cas_cnt;     // cycles since column strobe edge
	dc_cnt_t  addr_cnt;    // cycles since address change
	dc_cnt_t  st_cnt;      // cycles in current state
	logic     take;        // request accepted this cycle
	logic     page_ok;     // offered request can reuse the open row
	logic     close_ok;    // row strobe may rise now
	dc_req_t  start_req;   // request that starts from idle
	logic [LANES-1:0] lanes; // byte lanes strobed this access

	// drive write data on the enabled lanes
	function automatic dc_pins_t drive_data(input dc_pins_t p, input dc_req_t r);
		dc_pins_t q;
		q = p;
		q.low_byte_data     = r.wdata[BYTE_W-1:0];
		q.high_byte_data    = r.wdata[DATA_W-1:BYTE_W];
		q.low_byte_data_oe  = r.byte_en[LANE_LO];
		q.high_byte_data_oe = r.byte_en[LANE_HI];
		q.write_strobe_n    = 1'b0;
		return q;
	endfunction : drive_data

	// column address out; early write lowers write strobe ahead of the strobes
	function automatic dc_pins_t col_pins(input dc_pins_t p, input dc_req_t r);
		dc_pins_t q;
		q = p;
		q.address = r.col;
		if (r.cmd == CMD_WRITE) begin
			q = drive_data(q, r);
		end
		return q;
	endfunction : col_pins

	// sequencer
	always_comb begin
		core_next = core_reg;
		core_next.rvalid = 1'b0;
		take      = core_reg.ready && req_valid_in;
		// a write straight after a read closes the row: memory outputs need time to turn off
		page_ok   = (req_in.cmd != CMD_REFRESH) && (req_in.row == core_reg.cur.row)
			&& (ras_cnt < C_PAGE_LIMIT)
			&& !(req_in.cmd == CMD_WRITE && core_reg.cur.cmd == CMD_READ);
		close_ok  = (cas_cnt >= C_ROW_HOLD_PRE) && (addr_cnt >= C_ADDR_ROW_PRE)
			&& (ras_cnt >= C_ROW_ACT);
		start_req = core_reg.pend ? core_reg.cur : req_in;
		lanes     = (core_reg.cur.cmd == CMD_WRITE) ? core_reg.cur.byte_en : '1;
		case (core_reg.st)
			S_IDLE: begin
				// pending request first; it was taken while the row closed
				if (core_reg.pend || take) begin
					core_next.cur  = start_req;
					core_next.pend = 1'b0;
					if (start_req.cmd == CMD_REFRESH) begin
						// write strobe has been high through the whole precharge
						core_next.pins.low_byte_column_strobe_n  = 1'b0;
						core_next.pins.high_byte_column_strobe_n = 1'b0;
						core_next.st = S_CBR_COL;
					end else begin
						core_next.pins.row_strobe_n = 1'b0;
						core_next.pins.address      = start_req.row;
						core_next.st = S_ROW;
					end
				end
			end
			S_ROW: begin
				// row address stays until both its hold and the column delay pass
				if (st_cnt >= C_ROW_PHASE) begin
					core_next.pins = col_pins(core_reg.pins, core_reg.cur);
					core_next.st   = S_RCOL;
				end
			end
			S_RCOL: begin
				// also covers the column precharge when arriving from a page hit
				if (ras_cnt >= C_ROW_TO_COL && cas_cnt >= C_COL_PRE) begin
					// strobed lanes fall together; the device takes either order
					core_next.pins.low_byte_column_strobe_n  = !lanes[LANE_LO];
					core_next.pins.high_byte_column_strobe_n = !lanes[LANE_HI];
					if (core_reg.cur.cmd != CMD_WRITE) begin
						core_next.pins.output_enable_n = 1'b0;
					end
					core_next.st = (core_reg.cur.cmd == CMD_RMW) ? S_RMW_READ : S_COL;
				end
			end
			S_COL: begin
				// access time taken from the slowest path, so a late column is fine
				if (cas_cnt >= C_COL_LOW && addr_cnt >= C_COL_ADDR
					&& ras_cnt >= C_ROW_COL_LOW) begin
					if (core_reg.cur.cmd == CMD_READ) begin
						core_next.rdata  = {high_byte_data_in, low_byte_data_in};
						core_next.rvalid = 1'b1;
					end
					// both lanes rise together, well past the overlap time
					core_next.pins.low_byte_column_strobe_n  = 1'b1;
					core_next.pins.high_byte_column_strobe_n = 1'b1;
					core_next.pins.output_enable_n   = 1'b1;
					core_next.pins.write_strobe_n    = 1'b1;
					core_next.pins.low_byte_data_oe  = 1'b0;
					core_next.pins.high_byte_data_oe = 1'b0;
					core_next.st = S_CPRE;
				end
			end
			S_RMW_READ: begin
				// write strobe held off until all three read-write delays pass
				if (cas_cnt >= C_RMW_COL && addr_cnt >= C_RMW_ADDR
					&& ras_cnt >= C_RMW_ROW) begin
					core_next.rdata  = {high_byte_data_in, low_byte_data_in};
					core_next.rvalid = 1'b1;
					core_next.pins.output_enable_n = 1'b1;
					core_next.st = S_RMW_TURN;
				end
			end
			S_RMW_TURN: begin
				// memory outputs must be off before we drive the bus
				if (st_cnt >= C_OE_TO_DATA) begin
					core_next.pins = drive_data(core_reg.pins, core_reg.cur);
					core_next.st   = S_RMW_WRITE;
				end
			end
			S_RMW_WRITE: begin
				if (st_cnt >= C_RMW_WE_LOW) begin
					core_next.pins.low_byte_column_strobe_n  = 1'b1;
					core_next.pins.high_byte_column_strobe_n = 1'b1;
					core_next.pins.write_strobe_n    = 1'b1;
					core_next.pins.low_byte_data_oe  = 1'b0;
					core_next.pins.high_byte_data_oe = 1'b0;
					core_next.st = S_CPRE;
				end
			end
			S_CPRE: begin
				// same-row access within the page limit, except a write after a read: stay open; anything else waits while the row closes
				if (take && page_ok) begin
					core_next.cur  = req_in;
					core_next.pins = col_pins(core_reg.pins, req_in);
					core_next.st   = S_RCOL;
				end else begin
					if (take) begin
						core_next.cur  = req_in;
						core_next.pend = 1'b1;
					end
					if (close_ok) begin
						core_next.pins.row_strobe_n = 1'b1;
						core_next.st = S_RPRE;
					end
				end
			end
			S_RPRE: begin
				// also keeps columns high long enough after the row rise
				if (ras_cnt >= C_ROW_PRE) begin
					core_next.st = S_IDLE;
				end
			end
			S_CBR_COL: begin
				if (cas_cnt >= C_CBR_SETUP) begin
					core_next.pins.row_strobe_n = 1'b0;
					core_next.st = S_CBR_ROW;
				end
			end
			S_CBR_ROW: begin
				// write strobe never leaves high during a refresh
				if (ras_cnt >= C_CBR_HOLD) begin
					core_next.pins.low_byte_column_strobe_n  = 1'b1;
					core_next.pins.high_byte_column_strobe_n = 1'b1;
					core_next.st = S_CBR_END;
				end
			end
			S_CBR_END: begin
				if (ras_cnt >= C_ROW_ACT) begin
					core_next.pins.row_strobe_n = 1'b1;
					core_next.st = S_RPRE;
				end
			end
			default: begin
				// illegal code: release the memory and precharge
				core_next = CORE_RESET;
			end
		endcase
		core_next.ready = !core_next.pend
			&& (core_next.st == S_IDLE || core_next.st == S_CPRE);
	end

	// single state register
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			core_reg <= CORE_RESET;
		end else begin
			core_reg <= core_next;
		end
	end

	// interval counters restart on the edge that starts each interval
	dc_elapsed #(.W(CNT_W)) u_ras_cnt (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.clear_in   (core_next.pins.row_strobe_n != core_reg.pins.row_strobe_n),
		.count_out  (ras_cnt)
	);
	dc_elapsed #(.W(CNT_W)) u_cas_cnt (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.clear_in   ((core_next.pins.low_byte_column_strobe_n
			!= core_reg.pins.low_byte_column_strobe_n)
			|| (core_next.pins.high_byte_column_strobe_n
			!= core_reg.pins.high_byte_column_strobe_n)),
		.count_out  (cas_cnt)
	);
	dc_elapsed #(.W(CNT_W)) u_addr_cnt (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.clear_in   (core_next.pins.address != core_reg.pins.address),
		.count_out  (addr_cnt)
	);
	dc_elapsed #(.W(CNT_W)) u_st_cnt (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.clear_in   (core_next.st != core_reg.st),
		.count_out  (st_cnt)
	);

	// outputs straight from the state register
	assign pins_out   = core_reg.pins;
	assign ready_out  = core_reg.ready;
	assign rdata_out  = core_reg.rdata;
	assign rvalid_out = core_reg.rvalid;

endmodule : dc_ctrl

/* bench/dc_ctrl_properties.sv */
// concurrent strobe timing checks on the dram cycle controller pins
`timescale 1ns/1ns
module dc_ctrl_checker #(
	parameter int GRADE       = 0,      // counts below assume the fastest grade
	parameter int RASP_MAX_NS = 100000, // page row limit
	parameter int CNT_W       = 16      // counter width
) (
	// clock and reset
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	// watched pins
	input  wire dc_pkg::dc_pins_t pins_out
);
	import dc_pkg::*;
	// both column strobes high
	wire logic col_hi = pins_out.low_byte_column_strobe_n & pins_out.high_byte_column_strobe_n;
	wire logic row_n  = pins_out.row_strobe_n;    // row strobe
	wire logic wr_n   = pins_out.write_strobe_n;  // write strobe
	wire logic oe_n   = pins_out.output_enable_n; // output enable
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	row_precharge_a: assert property ($rose(row_n) |-> col_hi ##0 row_n [*3])
		else $error("row strobe high time too short");
	row_to_col_a: assert property ($fell(row_n) && col_hi |-> col_hi [*2])
		else $error("column strobe too soon after row fall");
	col_low_time_a: assert property ($fell(row_n) && col_hi |=> (!$rose(col_hi)) [*4])
		else $error("column strobe rose too soon after row fall");
	row_after_col_a: assert property ($fell(col_hi) && !row_n |-> !row_n [*2])
		else $error("row strobe rose too soon after column fall");
	page_row_hold_a: assert property ($rose(col_hi) && !row_n |-> !row_n [*3])
		else $error("row strobe rose too soon after column precharge");
	refresh_order_a: assert property ($fell(row_n) && !col_hi |->
		!$past(col_hi) && $past(wr_n) && wr_n) else $error("refresh strobe order broken");
	rmw_write_delay_a: assert property ($fell(wr_n) && !col_hi |->
		!$past(col_hi, 4) && !$past(row_n, 8)) else $error("read-write strobe too early");
	write_setup_a: assert property ($rose(col_hi) && !$past(wr_n) |-> !$past(wr_n, 2))
		else $error("write strobe low too briefly before column rise");
	data_after_oe_a: assert property ($rose(pins_out.low_byte_data_oe) ||
		$rose(pins_out.high_byte_data_oe) |-> $past(oe_n) && $past(oe_n, 2))
		else $error("data driven too soon after output enable release");
endmodule : dc_ctrl_checker

bind dc_ctrl dc_ctrl_checker #(.GRADE(GRADE), .RASP_MAX_NS(RASP_MAX_NS), .CNT_W(CNT_W))
	u_dc_ctrl_checker (.clock_in(clock_in), .reset_n_in(reset_n_in), .pins_out(pins_out));

/* bench/dc_dram_model.sv */
// behavioural page-mode dram answering the controller strobes
`timescale 1ns/1ns
module dc_dram_model (
	// clock and pins from the controller
	input  wire logic                 clock_in,
	input  wire dc_pkg::dc_pins_t     pins_in,
	// data back and refresh count
	output logic [dc_pkg::BYTE_W-1:0] low_byte_data_out,
	output logic [dc_pkg::BYTE_W-1:0] high_byte_data_out,
	output int                        refreshes_out
);
	import dc_pkg::*;
	logic [DATA_W-1:0] mem_reg [int];   // sparse store keyed by row and column
	logic [ADDR_W-1:0] row_reg = '0;    // latched row
	logic [ADDR_W-1:0] col_reg = '0;    // latched column
	logic              prev_row = 1'b1; // strobes seen at the last edge
	logic              prev_col = 1'b1;
	logic              col_hi;
	logic [DATA_W-1:0] word;
	initial refreshes_out = 0;
	initial low_byte_data_out = 8'h00;
	initial high_byte_data_out = 8'h00;
	// strobes are registered in the controller, so edges are seen one clock late
	always @(posedge clock_in) begin
		col_hi = pins_in.low_byte_column_strobe_n & pins_in.high_byte_column_strobe_n;
		if (prev_row && !pins_in.row_strobe_n && !col_hi) refreshes_out++;
		else if (prev_row && !pins_in.row_strobe_n) row_reg = pins_in.address;
		// first falling byte strobe latches, lanes in any order
		if (prev_col && !col_hi && !pins_in.row_strobe_n) col_reg = pins_in.address;
		word = mem_reg.exists({row_reg, col_reg}) ? mem_reg[{row_reg, col_reg}] : 16'h0000;
		// data taken once both write and lane strobe are low
		if (!pins_in.write_strobe_n && !pins_in.low_byte_column_strobe_n &&
			pins_in.low_byte_data_oe) word[7:0] = pins_in.low_byte_data;
		if (!pins_in.write_strobe_n && !pins_in.high_byte_column_strobe_n &&
			pins_in.high_byte_data_oe) word[15:8] = pins_in.high_byte_data;
		if (!col_hi && !pins_in.row_strobe_n) mem_reg[{row_reg, col_reg}] = word;
		// undriven lanes toggle so stale data never looks valid
		low_byte_data_out <= (!pins_in.output_enable_n && !pins_in.low_byte_column_strobe_n) ?
			word[7:0] : ~low_byte_data_out;
		high_byte_data_out <= (!pins_in.output_enable_n && !pins_in.high_byte_column_strobe_n) ?
			word[15:8] : ~high_byte_data_out;
		prev_row = pins_in.row_strobe_n;
		prev_col = col_hi;
	end
endmodule : dc_dram_model

/* bench/tb_top.sv */
// self-checking bench: corner and random accesses through the dram model
`timescale 1ns/1ns
module tb_top;
	import dc_pkg::*;
	logic              clock_in = 1'b0;
	logic              reset_n_in = 1'b0;
	logic              req_valid_in = 1'b0;
	dc_req_t           req_in = '0;
	logic              ready_out;
	logic              rvalid_out;
	logic [DATA_W-1:0] rdata_out;
	dc_pins_t          pins_out;
	logic [BYTE_W-1:0] lo_data;
	logic [BYTE_W-1:0] hi_data;
	int                refreshes;
	int                mismatches = 0;
	int                n_tests = 0;
	int                row_falls = 0;
	logic [DATA_W-1:0] shadow [int];  // expected memory contents
	logic [DATA_W-1:0] exp_q [$];     // expected read words in order
	always #5 clock_in = ~clock_in;
	dc_ctrl #(.GRADE(0), .RASP_MAX_NS(3000), .CNT_W(16)) u_dc_ctrl (.clock_in(clock_in),
		.reset_n_in(reset_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
		.ready_out(ready_out), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
		.pins_out(pins_out), .low_byte_data_in(lo_data), .high_byte_data_in(hi_data));
	dc_dram_model u_dc_dram_model (.clock_in(clock_in), .pins_in(pins_out),
		.low_byte_data_out(lo_data), .high_byte_data_out(hi_data), .refreshes_out(refreshes));
	function automatic logic [15:0] stored(input int k);
		return shadow.exists(k) ? shadow[k] : 16'h0000;
	endfunction : stored
	function automatic logic [15:0] merge(input logic [15:0] old, wd, input logic [1:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction : merge
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	// offer one request and keep it offered until taken; valid stays up
	task automatic issue(input dc_cmd_t cmd, input logic [9:0] r, c, input logic [1:0] be,
		input logic [15:0] wd);
		int k;
		req_in = '{cmd, r, c, be, wd};
		req_valid_in = 1'b1;
		for (k = 0; k < 300 && ready_out !== 1'b1; k++) begin
			@(posedge clock_in);
			#1;
		end
		if (k == 300) begin
			mismatches++;
			close_out();
		end else begin
			@(posedge clock_in);
			#1;
			if (cmd == CMD_READ || cmd == CMD_RMW) exp_q.push_back(stored({r, c}));
			if (cmd == CMD_WRITE || cmd == CMD_RMW) shadow[{r, c}] = merge(stored({r, c}), wd, be);
		end
	endtask : issue
	// release the request and wait for all answers and a closed row
	task automatic drain(input string name);
		int k;
		req_valid_in = 1'b0;
		for (k = 0; k < 300 && !(exp_q.size() == 0 && ready_out === 1'b1 &&
			pins_out.row_strobe_n === 1'b1); k++) begin
			@(posedge clock_in);
			#1;
		end
		if (k == 300) begin
			mismatches++;
			close_out();
		end else $display("test %s done", name);
	endtask : drain
	// read answers are compared in the order they were taken
	always @(posedge clock_in) begin
		#1;
		if (rvalid_out === 1'b1) check("read data", exp_q.pop_front(), rdata_out);
	end
	always @(negedge pins_out.row_strobe_n) row_falls++;
	initial begin
		int mark;
		void'($urandom(32'ha0fd_9c7b));
		repeat (10) @(posedge clock_in);
		check("ready in reset", 16'h0000, {15'h0000, ready_out});
		check("row strobe in reset", 16'h0001, {15'h0000, pins_out.row_strobe_n});
		#1;
		reset_n_in = 1'b1;
		// single-lane writes must leave the other byte alone
		issue(CMD_WRITE, 10'h005, 10'h009, 2'h3, 16'h1234);
		issue(CMD_WRITE, 10'h005, 10'h009, 2'h1, 16'hab56);
		issue(CMD_WRITE, 10'h005, 10'h00a, 2'h2, 16'hcdef);
		issue(CMD_READ, 10'h005, 10'h009, 2'h3, 16'h0000);
		issue(CMD_READ, 10'h005, 10'h00a, 2'h3, 16'h0000);
		drain("byte lanes");
		// back-to-back same row opens the row once
		mark = row_falls;
		issue(CMD_READ, 10'h005, 10'h009, 2'h3, 16'h0000);
		issue(CMD_READ, 10'h005, 10'h00a, 2'h3, 16'h0000);
		drain("page hit");
		check("row openings", 16'h0001, 16'(row_falls - mark));
		mark = row_falls;
		issue(CMD_READ, 10'h005, 10'h009, 2'h3, 16'h0000);
		issue(CMD_READ, 10'h006, 10'h009, 2'h3, 16'h0000);
		drain("page miss");
		check("row openings", 16'h0002, 16'(row_falls - mark));
		issue(CMD_RMW, 10'h005, 10'h009, 2'h2, 16'h7788);
		issue(CMD_READ, 10'h005, 10'h009, 2'h3, 16'h0000);
		drain("read-write");
		mark = refreshes;
		issue(CMD_REFRESH, 10'h000, 10'h000, 2'h0, 16'h0000);
		issue(CMD_READ, 10'h005, 10'h00a, 2'h3, 16'h0000);
		drain("refresh");
		check("refresh count", 16'h0001, 16'(refreshes - mark));
		repeat (40) issue(dc_cmd_t'($urandom_range(3)), 10'($urandom_range(3)),
			10'($urandom_range(7)), 2'($urandom_range(3, 1)), 16'($urandom));
		drain("random mix");
		close_out();
	end
endmodule : tb_top
